// ===== src/ddcrs_pkg.sv
// package for the ddc routing / sync control register bank
// assumes a single 250 MHz clock domain and an axi4-lite host
`default_nettype none

package ddcrs_pkg;

  // ==========================================================
  // register map (byte addresses on the axi4-lite bus)
  localparam logic [7:0] ADDR_ROUTE     = 8'h00;
  localparam logic [7:0] ADDR_SYNC      = 8'h04;
  localparam logic [7:0] ADDR_CTRL      = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0c;
  // printed global word locations kept for reference
  localparam logic [15:0] GWL_SYNC      = 16'hf802;

  // ==========================================================
  // routing register fields
  localparam int ROUTE_BACKEND_LO  = 8;   // bits 10:8 -> ch3..ch1
  localparam int ROUTE_GAIN_LO     = 4;   // bits 7:4  -> ch3..ch0
  localparam int ROUTE_SERIAL_LO   = 0;   // bits 3:0  -> ch3..ch0
  localparam int ROUTE_SRCMUX1     = 12;
  localparam int ROUTE_PW_LO       = 20;  // interrupt pulse width 23:20
  localparam logic [31:0] ROUTE_WMASK   = 32'h00f0_17ef;
  localparam logic [31:0] ROUTE_RESET   = 32'h0010_0000;

  // ==========================================================
  // sync register per-channel field (bit index inside 8-bit field)
  localparam int SF_IRQ     = 7;
  localparam int SF_INHOLD  = 6;
  localparam int SF_CARRIER = 5;
  localparam int SF_FILTER  = 4;
  localparam int SF_GAIN    = 3;
  localparam int SF_TIMING  = 2;
  localparam int SF_COMB    = 1;
  localparam int SF_SERIAL  = 0;
  localparam logic [31:0] SYNC_RESET    = 32'h0000_0000;

  // ==========================================================
  // control register fields
  localparam int CTRL_SWRESET   = 0;  // write 1: processor reset pulse
  localparam int CTRL_SCLKRST   = 1;  // serial clock divider reset enable
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // ==========================================================
  // status register fields, read only
  localparam int STAT_CNT_LO  = 0;   // interrupt pulse counter 3:0
  localparam int STAT_INEN    = 4;
  localparam int STAT_HOLD    = 5;
  localparam int STAT_GATED   = 6;
  localparam int STAT_BUSY_LO = 8;   // filter busy, one bit per channel

  // ==========================================================
  // timing
  localparam int FILTER_INIT_CYCLES = 32;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : ddcrs_pkg

`default_nettype wire

// ===== src/ddcrs_top.sv
// global routing and sync control of a four-channel downconverter
// assumes axi4-lite host on clk_i, sync_in_pulse synchronous to clk_i
// Behaviour
// R1: ch1-3 backend input: comb or external mux
// R2: ch0-2 gain loop: own filter or external
// R3: host keeps ch3 external gain bit zero
// R4: serial output enable per channel
// R5: irq-per-output bit raises interrupt per word; code drops words arriving during a pulse
// R6: host enables output interrupt on one channel
// R7: processor reset with bit set holds input off
// R8: reset pin always holds input, sets gated
// R9: input released on sample with sync pulse
// R10: sync loads carrier frequency from holding
// R11: phase clear on load aligns channel phase
// R12: sync resets filter engine, 32 cycles init
// R13: sync resets gain control loop
// R14: sync loads timing oscillator frequency
// R15: sync resets comb decimation counter
// R16: sync resets serial block, optionally divider
// R17: four 8-bit fields, channel 0 highest
// R18: interrupt pulse 1-15 clocks, pin reset only
// R19: ch1 external mux: ch0 comb or filter
// R20: all sync actions same cycle, all channels
`default_nettype none

module ddcrs_top
  import ddcrs_pkg::*;
#(
  parameter int NCH = 4
) (
  // clock and reset
  input  wire  logic              clk_i,
  input  wire  logic              resetn_i,
  // axi4-lite write address
  input  wire  logic [7:0]        s_axi_awaddr_i,
  input  wire  logic              s_axi_awvalid_i,
  output logic                    s_axi_awready_o,
  // axi4-lite write data
  input  wire  logic [31:0]       s_axi_wdata_i,
  input  wire  logic [3:0]        s_axi_wstrb_i,
  input  wire  logic              s_axi_wvalid_i,
  output logic                    s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp_o,
  output logic                    s_axi_bvalid_o,
  input  wire  logic              s_axi_bready_i,
  // axi4-lite read
  input  wire  logic [7:0]        s_axi_araddr_i,
  input  wire  logic              s_axi_arvalid_i,
  output logic                    s_axi_arready_o,
  output logic [31:0]             s_axi_rdata_o,
  output logic [1:0]              s_axi_rresp_o,
  output logic                    s_axi_rvalid_o,
  input  wire  logic              s_axi_rready_i,
  // datapath events
  input  wire  logic              sync_in_pulse_i,
  input  wire  logic [NCH-1:0]    word_out_i,
  // routing selects
  output logic [NCH-1:0]          backend_ext_sel_o,
  output logic [NCH-1:0]          gain_ext_sel_o,
  output logic [NCH-1:0]          serial_en_o,
  output logic                    chan1_source_selector_o,
  // sync actions, one-cycle pulses, then the per-channel filter busy levels
  output logic [NCH-1:0]          carrier_load_o,
  output logic [NCH-1:0]          filter_reset_o,
  output logic [NCH-1:0]          gain_reset_o,
  output logic [NCH-1:0]          timing_load_o,
  output logic [NCH-1:0]          comb_reset_o,
  output logic [NCH-1:0]          serial_reset_o,
  output logic                    sclk_div_reset_o,
  output logic [NCH-1:0]          filter_busy_o,
  // input gating and interrupt
  output logic                    input_enable_o,
  output logic                    input_gated_o,
  output logic                    irq_o
);

  // ==========================================================
  // bus slave
  logic [31:0] route_reg;
  logic [31:0] sync_reg;
  logic [31:0] ctrl_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wr_go;
  logic        wr_hit;
  logic        sw_reset;
  logic        wr_route;
  logic        wr_sync;
  logic        wr_ctrl;
  logic [31:0] status_word;
  logic        hold_reg;
  logic [3:0]  pulse_cnt_reg;

  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  assign wr_go  = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_hit = (awaddr_reg == ADDR_ROUTE) || (awaddr_reg == ADDR_SYNC)
                  || (awaddr_reg == ADDR_CTRL);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr_i[7:2], 2'b00};
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata_i;
        wstrb_reg  <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // write decode
  assign wr_route = wr_go && (awaddr_reg == ADDR_ROUTE);
  assign wr_sync  = wr_go && (awaddr_reg == ADDR_SYNC);
  assign wr_ctrl  = wr_go && (awaddr_reg == ADDR_CTRL);

  // reserved bits and the ch3 external gain bit are masked to zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      route_reg <= ROUTE_RESET;
      sync_reg  <= SYNC_RESET;
      ctrl_reg  <= CTRL_RESET;
    end else begin
      if (wr_route) begin
        route_reg <= merge(route_reg, wdata_reg, wstrb_reg) & ROUTE_WMASK; // [R3]
      end
      if (wr_sync) begin
        sync_reg <= merge(sync_reg, wdata_reg, wstrb_reg);
      end
      if (wr_ctrl) begin
        ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_0002;
      end
    end
  end

  // self-clearing processor reset strobe, never stored
  assign sw_reset = wr_ctrl && wstrb_reg[0] && wdata_reg[CTRL_SWRESET];

  // ==========================================================
  // status word, read only
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_CNT_LO +: 4]    = pulse_cnt_reg;
    status_word[STAT_INEN]           = input_enable_o;
    status_word[STAT_HOLD]           = hold_reg;
    status_word[STAT_GATED]          = input_gated_o;
    status_word[STAT_BUSY_LO +: NCH] = filter_busy_o;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      unique case ({s_axi_araddr_i[7:2], 2'b00})
        ADDR_ROUTE:  rdata_reg <= route_reg;
        ADDR_SYNC:   rdata_reg <= sync_reg;
        ADDR_CTRL:   rdata_reg <= ctrl_reg;
        ADDR_STATUS: rdata_reg <= status_word;
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // routing selects
  always_comb begin
    backend_ext_sel_o = '0;
    for (int c = 1; c < NCH; c++) begin
      backend_ext_sel_o[c] = route_reg[ROUTE_BACKEND_LO + NCH - 1 - c]; // [R1]
    end
    for (int c = 0; c < NCH; c++) begin
      gain_ext_sel_o[c] = route_reg[ROUTE_GAIN_LO + NCH - 1 - c];       // [R2]
      serial_en_o[c]    = route_reg[ROUTE_SERIAL_LO + NCH - 1 - c];     // [R4]
    end
  end
  assign chan1_source_selector_o = route_reg[ROUTE_SRCMUX1];            // [R19]

  // ==========================================================
  // sync actions, every channel on the same edge
  logic [NCH-1:0] irq_req;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      localparam int B = (NCH - 1 - g) * 8; // [R17]
      logic [5:0] fcnt_reg;
      logic [7:0] fld;
      assign fld = sync_reg[B +: 8];
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          carrier_load_o[g] <= 1'b0;
          filter_reset_o[g] <= 1'b0;
          gain_reset_o[g]   <= 1'b0;
          timing_load_o[g]  <= 1'b0;
          comb_reset_o[g]   <= 1'b0;
          serial_reset_o[g] <= 1'b0;
        end else begin
          carrier_load_o[g] <= sync_in_pulse_i && fld[SF_CARRIER]; // [R10] [R11] [R20]
          filter_reset_o[g] <= sync_in_pulse_i && fld[SF_FILTER];  // [R12]
          gain_reset_o[g]   <= sync_in_pulse_i && fld[SF_GAIN];    // [R13]
          timing_load_o[g]  <= sync_in_pulse_i && fld[SF_TIMING];  // [R14]
          comb_reset_o[g]   <= sync_in_pulse_i && fld[SF_COMB];    // [R15]
          serial_reset_o[g] <= sync_in_pulse_i && fld[SF_SERIAL];  // [R16]
        end
      end
      // engine busy while its pointers reinitialise
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          fcnt_reg <= 6'h00;
        end else if (sync_in_pulse_i && fld[SF_FILTER]) begin
          fcnt_reg <= 6'(FILTER_INIT_CYCLES);                               // [R12]
        end else if (fcnt_reg != 6'h00) begin
          fcnt_reg <= fcnt_reg - 6'h01;
        end
      end
      assign filter_busy_o[g] = (fcnt_reg != 6'h00);
      assign irq_req[g] = word_out_i[g] && fld[SF_IRQ];                     // [R5]
    end
  endgenerate

  // divider reset follows any channel that has its serial reset enabled
  logic serial_any;
  always_comb begin
    serial_any = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      serial_any = serial_any | sync_reg[(NCH - 1 - c) * 8 + SF_SERIAL];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_div_reset_o <= 1'b0;
    end else begin
      sclk_div_reset_o <= sync_in_pulse_i && ctrl_reg[CTRL_SCLKRST] && serial_any; // [R16]
    end
  end

  // ==========================================================
  // input enable hold and release
  logic hold_req;
  always_comb begin
    hold_req = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      hold_req = hold_req | sync_reg[(NCH - 1 - c) * 8 + SF_INHOLD];
    end
  end

  // hold starts at pin reset; release aligns to the sync sample
  // a processor reset in the sync cycle keeps the hold: set wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_reg <= 1'b1;                              // [R8]
    end else if (sw_reset && hold_req) begin
      hold_reg <= 1'b1;                              // [R7]
    end else if (sync_in_pulse_i) begin
      hold_reg <= 1'b0;                              // [R9]
    end
  end
  // the sample that comes with the sync pulse is already taken
  assign input_enable_o = resetn_i && (!hold_reg || sync_in_pulse_i)
                          && !(sw_reset && hold_req); // [R7] [R8] [R9]

  // gated mode is set only by the pin; software has no path to clear it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_gated_o <= 1'b1;                         // [R8]
    end else begin
      input_gated_o <= input_gated_o;
    end
  end

  // ==========================================================
  // interrupt pulse; only the pin clears the counter
  // words that arrive during a pulse are dropped, not queued
  logic [3:0] pw;
  assign pw = route_reg[ROUTE_PW_LO +: 4];
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_cnt_reg <= 4'h0;
    end else if (pulse_cnt_reg != 4'h0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 4'h1;         // [R18]
    end else if (|irq_req) begin
      pulse_cnt_reg <= (pw == 4'h0) ? 4'h1 : pw;     // [R18]
    end
  end
  assign irq_o = (pulse_cnt_reg != 4'h0);            // [R5]

endmodule : ddcrs_top

`default_nettype wire

// ===== test/ddcrs_props.sv
// concurrent checks on the routing / sync control block ports
// assumes bind from the bench top; one clock, async active-low reset
`default_nettype none

module ddcrs_props
  import ddcrs_pkg::*;
#(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic           clk_i,
  input wire logic           resetn_i,
  // watched signals
  input wire logic           sync_in_pulse_i,
  input wire logic [NCH-1:0] word_out_i,
  input wire logic [NCH-1:0] backend_ext_sel_o,
  input wire logic [NCH-1:0] carrier_load_o,
  input wire logic [NCH-1:0] filter_reset_o,
  input wire logic [NCH-1:0] gain_reset_o,
  input wire logic [NCH-1:0] timing_load_o,
  input wire logic [NCH-1:0] comb_reset_o,
  input wire logic [NCH-1:0] serial_reset_o,
  input wire logic           sclk_div_reset_o,
  input wire logic [NCH-1:0] filter_busy_o,
  input wire logic           input_enable_o,
  input wire logic           input_gated_o,
  input wire logic           irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // ==========================================================
  // helper: length of the current ch0 busy run
  logic [6:0] busy_run_reg;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) busy_run_reg <= 7'h00;
    else busy_run_reg <= filter_busy_o[0] ? busy_run_reg + 7'h01 : 7'h00;
  end

  // ==========================================================
  // sync actions only in the cycle after a sampled sync
  sequence s_after_sync;
    $past(sync_in_pulse_i);
  endsequence

  AST_CARRIER: assert property ((|carrier_load_o) |-> s_after_sync)
    else $error("carrier load without sync");
  AST_FILTER: assert property ((|filter_reset_o) |-> s_after_sync)
    else $error("filter reset without sync");
  AST_GAIN: assert property ((|gain_reset_o) |-> s_after_sync)
    else $error("gain reset without sync");
  AST_TIMING: assert property ((|timing_load_o) |-> s_after_sync)
    else $error("timing load without sync");
  AST_COMB: assert property ((|comb_reset_o) |-> s_after_sync)
    else $error("comb reset without sync");
  AST_SERIAL: assert property ((|serial_reset_o) |-> s_after_sync)
    else $error("serial reset without sync");
  AST_SCLK: assert property (sclk_div_reset_o |-> (|serial_reset_o))
    else $error("divider reset without serial reset");
  AST_BUSY: assert property ($fell(filter_busy_o[0]) |-> busy_run_reg == 7'd32)
    else $error("filter init length wrong");
  AST_IRQ: assert property ($rose(irq_o) |-> $past(|word_out_i) || $past(|word_out_i, 2))
    else $error("interrupt without output word");
  AST_RELEASE: assert property ($rose(input_enable_o) |-> sync_in_pulse_i)
    else $error("input released without sync");
  AST_GATED: assert property (input_gated_o |=> input_gated_o)
    else $error("gated mode lost");
  AST_BACKEND0: assert property (backend_ext_sel_o[0] == 1'b0)
    else $error("ch0 backend select set");
endmodule : ddcrs_props

`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the routing / sync control block
// assumes the package constants for register offsets and field layout
`default_nettype none

module tb;
  import ddcrs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 4;
  localparam int LIMIT = 5000;  // about twenty times the expected run
  logic clk_i = 1'b0, resetn_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, sync = 1'b0;
  logic awready, wready, arready, bvalid, rvalid, sclk_rst, in_en, gated, irq, sel1;
  logic [1:0] bresp, rresp;
  logic [3:0] word_out = 4'h0, be, ge, se, cl, fr, gr, tl, cr, sr, fb;
  int n_errors = 0, checked = 0, cycles = 0;
  always #2 clk_i = ~clk_i;

  // bready/rready held high: master always accepts responses
  ddcrs_top #(.NCH(NCH)) dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1),
    .sync_in_pulse_i(sync), .word_out_i(word_out),
    .backend_ext_sel_o(be), .gain_ext_sel_o(ge), .serial_en_o(se),
    .chan1_source_selector_o(sel1), .carrier_load_o(cl), .filter_reset_o(fr),
    .gain_reset_o(gr), .timing_load_o(tl), .comb_reset_o(cr), .serial_reset_o(sr),
    .sclk_div_reset_o(sclk_rst), .filter_busy_o(fb), .input_enable_o(in_en),
    .input_gated_o(gated), .irq_o(irq));

  // ==========================================================
  // common tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_ok = 1'b0;
    bit w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    r = bresp;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : axr

  // one sync sample; captures all action pulses in the following cycle
  task automatic pulse(output logic [31:0] v);
    sync <= 1'b1;
    @(posedge clk_i);
    sync <= 1'b0;
    #1;
    v = {7'h0, sclk_rst, cl, fr, gr, tl, cr, sr};
    @(posedge clk_i);
  endtask : pulse

  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    chk(in_en, 0);
    chk(gated, 1);
    axr(ADDR_ROUTE, d, r);
    chk(d, ROUTE_RESET);
    axr(ADDR_SYNC, d, r);
    chk(d, SYNC_RESET);
    axr(8'h10, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    axw(8'h10, 32'hffff_ffff, r);
    chk(r, RESP_SLVERR);
  endtask : t_reset

  task automatic t_route;
    logic [31:0] v[2] = '{32'h0010_05a9, 32'h0010_1246};
    logic [31:0] d;
    logic [1:0] r;
    foreach (v[i]) begin
      axw(ADDR_ROUTE, v[i], r);
      chk(be, {v[i][8], v[i][9], v[i][10], 1'b0});
      chk(ge, {v[i][4], v[i][5], v[i][6], v[i][7]});
      chk(se, {v[i][0], v[i][1], v[i][2], v[i][3]});
      chk(sel1, v[i][12]);
      axr(ADDR_ROUTE, d, r);
      chk(d, v[i] & ROUTE_WMASK);
    end
  endtask : t_route

  task automatic t_sync;
    logic [31:0] v;
    logic [1:0] r;
    axw(ADDR_CTRL, 32'h2, r);
    for (int c = 0; c < 4; c++) begin
      for (int b = 0; b < 6; b++) begin
        axw(ADDR_SYNC, 32'h1 << (8 * (3 - c) + b), r);
        pulse(v);
        chk(v, (32'h1 << (4 * b + c)) | ((b == 0) ? 32'h0100_0000 : 32'h0));
        if (b == 4) chk(fb[c], 1'b1);
      end
    end
  endtask : t_sync

  task automatic t_hold;
    logic [31:0] d;
    logic [1:0] r;
    chk(in_en, 1);
    axw(ADDR_CTRL, 32'h3, r);
    chk(in_en, 1);
    axw(ADDR_SYNC, 32'h0040_0000, r);
    axw(ADDR_CTRL, 32'h3, r);
    chk(in_en, 0);
    repeat (40) @(posedge clk_i);
    chk(in_en, 0);
    axr(ADDR_STATUS, d, r);
    chk(d, (32'h1 << STAT_HOLD) | (32'h1 << STAT_GATED));
    sync <= 1'b1;
    #1;
    chk(in_en, 1);
    @(posedge clk_i);
    sync <= 1'b0;
    @(posedge clk_i);
    chk(in_en, 1);
    axr(ADDR_STATUS, d, r);
    chk(d, (32'h1 << STAT_INEN) | (32'h1 << STAT_GATED));
  endtask : t_hold

  task automatic t_irq;
    int n;
    logic [1:0] r;
    axw(ADDR_ROUTE, 32'h0030_0000, r);
    axw(ADDR_SYNC, 32'h8000_0000, r);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      word_out <= (k == 0) ? 4'h1 : 4'h2;
      @(posedge clk_i);
      word_out <= 4'h0;
      repeat (10) begin
        @(posedge clk_i);
        if (irq === 1'b1) n++;
      end
      chk(32'(n), (k == 0) ? 32'd3 : 32'd0);
    end
  endtask : t_irq

  // pulse survives a processor reset, pin reset clears it; input held and gated again
  task automatic t_pin;
    logic [31:0] d;
    logic [1:0] r;
    axw(ADDR_ROUTE, 32'h00f0_0000, r);
    word_out <= 4'h1;
    @(posedge clk_i);
    word_out <= 4'h0;
    axw(ADDR_CTRL, 32'h1, r);
    chk(irq, 1);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    chk(irq, 0);
    chk(in_en, 0);
    chk(gated, 1);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    axr(ADDR_ROUTE, d, r);
    chk(d, ROUTE_RESET);
  endtask : t_pin

  // ==========================================================
  // verdict and run control
  task automatic end_of_test;
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("wrong value at %0t: run timed out", $time);
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_route();
    t_sync();
    t_hold();
    t_irq();
    t_pin();
    end_of_test();
  end
endmodule : tb

bind ddcrs_top ddcrs_props #(.NCH(NCH)) props_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .sync_in_pulse_i(sync_in_pulse_i),
  .word_out_i(word_out_i), .backend_ext_sel_o(backend_ext_sel_o),
  .carrier_load_o(carrier_load_o), .filter_reset_o(filter_reset_o),
  .gain_reset_o(gain_reset_o), .timing_load_o(timing_load_o),
  .comb_reset_o(comb_reset_o), .serial_reset_o(serial_reset_o),
  .sclk_div_reset_o(sclk_div_reset_o), .filter_busy_o(filter_busy_o),
  .input_enable_o(input_enable_o), .input_gated_o(input_gated_o), .irq_o(irq_o));

`default_nettype wire
